// >>> logic/sfct_period_gen.sv
// Produces one pulse every 1024 * filter_word master clock cycles
module sfct_period_gen
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic restart_in,
   input wire logic [9:0] filter_word_in,
   output logic tick_out
);
   logic [9:0] base_ff;
   logic [9:0] word_ff;
   logic [9:0] nxt_base;
   logic [9:0] nxt_word;
   logic base_wrap;
   logic word_wrap;
   logic [9:0] fw_eff;

   // Zero would stall the rate; treat as the least legal word
   assign fw_eff = (filter_word_in == 10'h000) ? sfct_pkg::FW_MIN : filter_word_in;
   assign base_wrap = (base_ff == sfct_pkg::BASE_LAST);
   assign word_wrap = (word_ff >= fw_eff - 10'h001);
   assign nxt_base = restart_in ? 10'h000 : base_ff + 10'h001;
   assign nxt_word = restart_in ? 10'h000 :
                     !base_wrap ? word_ff :
                     word_wrap ? 10'h000 : word_ff + 10'h001;
   assign tick_out = !restart_in && base_wrap && word_wrap;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         base_ff <= 10'h000;
         word_ff <= 10'h000;
      end
      else
      begin
         base_ff <= nxt_base;
         word_ff <= nxt_word;
      end
   end
endmodule // sfct_period_gen

// >>> logic/sfct_pkg.sv
package sfct_pkg;
   localparam int FW_W = 10;
   localparam logic [9:0] FW_RST = 10'h060;
   localparam logic [9:0] FW_MIN = 10'h001;
   localparam int BASE_CNT_W = 10;
   localparam logic [9:0] BASE_LAST = 10'h3FF;
   localparam logic [2:0] SETTLE_SINC4 = 3'h4;
   localparam logic [2:0] SETTLE_THIRD_ORDER_SELECT = 3'h3;
   localparam logic [2:0] STEP_EXTRA = 3'h1;
   localparam int MODE_ZERO_LAT_BIT = 11;
   localparam logic [9:0] NOTCH_FW = 10'h060;
   localparam real CLK_MHZ = 20.0;
   localparam int CLK_HZ = 20000000;
   localparam logic [1:0] ADDR_MODE = 2'h0;
   localparam logic [1:0] ADDR_FILT = 2'h1;
   localparam logic [1:0] ADDR_STAT = 2'h2;
   localparam logic [1:0] ADDR_CNT = 2'h3;
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam int MODE_THIRD_ORDER_SELECT_BIT = 15;
   localparam int MODE_NOTCH_BIT = 13;
   typedef enum logic [1:0]
   {
      SFCT_IDLE = 2'b00,
      SFCT_SETTLE = 2'b01,
      SFCT_RUN = 2'b10
   } sfct_state_t;
endpackage

// >>> logic/sfct_top.sv
// Contract
// R01: After reset the fourth-order filter is in use with chopping off until software selects another.
// R02: In normal mode one conversion completes every 1024 times filter_word clock cycles, word 1 to 1023.
// R03: The fourth-order filter settles in four output periods.
// R04: With fourth order a channel change restarts the filter and the first result waits a full settle.
// R05: With fourth order a step is accurate only four conversions later, five if mid-conversion.
// R06: Mode bit 11 selects zero latency, giving every conversion a full settling time.
// R07: Zero latency with fourth order takes 4 times 1024 times filter_word cycles per conversion.
// R08: In zero latency a synchronous step gives settled outputs and an asynchronous one spoils one output.
// R09: With word 96 the sixty hertz notch bit adds a 60 Hz notch and leaves the output rate unchanged.
// R10: Writing the third-order select bit as one replaces the fourth-order filter.
// R11: The third-order filter settles in three output periods.
// R12: With third order a channel change restarts the filter and the first result waits a full settle.
// R13: With third order a step is accurate only three conversions later, four if mid-conversion.
// R14: Each settled conversion is flagged once; those inside a settling window are suppressed.
// R15: Zero latency with third order takes 3 times 1024 times filter_word cycles per conversion.
module sfct_top
(
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic [1:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic CHAN_CHANGE_IN,
   input wire logic STEP_IN,
   input wire logic ENABLE_IN,
   output logic [31:0] RDATA_OUT,
   output logic DATA_READY_OUT,
   output logic FILTER_RESET_OUT,
   output logic SETTLED_OUT,
   output logic THIRD_ORDER_OUT,
   output logic ZERO_LATENCY_OUT,
   output logic NOTCH_ACTIVE_OUT
);
   logic [31:0] mode_ff;
   logic [9:0] filter_word_ff;
   logic [31:0] rdata_ff;
   logic [31:0] conv_cnt_ff;
   logic [2:0] phase_ff;
   logic [2:0] step_left_ff;
   logic ready_ff;
   logic freset_ff;
   logic chan_s1_ff;
   logic chan_s2_ff;
   logic chan_s3_ff;
   logic step_s1_ff;
   logic step_s2_ff;
   logic step_s3_ff;
   logic en_s1_ff;
   logic en_s2_ff;
   sfct_pkg::sfct_state_t state_ff;
   sfct_pkg::sfct_state_t nxt_state;
   logic [2:0] nxt_phase;
   logic [2:0] nxt_step_left;
   logic [31:0] nxt_rdata;
   logic [31:0] nxt_mode;
   logic [9:0] nxt_filter_word;
   logic tick;
   logic restart;
   logic third_order;
   logic zero_lat;
   logic notch;
   logic [2:0] settle_n;
   logic chan_edge;
   logic step_edge;
   logic wr_mode;
   logic wr_filt;
   logic conv_done;
   logic step_mid;

   function automatic logic [2:0] settle_periods(input logic third_order_select);
      settle_periods = third_order_select ? sfct_pkg::SETTLE_THIRD_ORDER_SELECT : sfct_pkg::SETTLE_SINC4;
   endfunction

   // Channel, step and enable pins pass two flops before any logic reads them
   always_ff @(posedge CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         chan_s1_ff <= 1'b0;
         chan_s2_ff <= 1'b0;
         chan_s3_ff <= 1'b0;
         step_s1_ff <= 1'b0;
         step_s2_ff <= 1'b0;
         step_s3_ff <= 1'b0;
         en_s1_ff <= 1'b0;
         en_s2_ff <= 1'b0;
      end
      else
      begin
         chan_s1_ff <= CHAN_CHANGE_IN;
         chan_s2_ff <= chan_s1_ff;
         chan_s3_ff <= chan_s2_ff;
         step_s1_ff <= STEP_IN;
         step_s2_ff <= step_s1_ff;
         step_s3_ff <= step_s2_ff;
         en_s1_ff <= ENABLE_IN;
         en_s2_ff <= en_s1_ff;
      end
   end

   assign chan_edge = chan_s2_ff && !chan_s3_ff;
   assign step_edge = step_s2_ff && !step_s3_ff;

   assign wr_mode = WR_IN && (ADDR_IN == sfct_pkg::ADDR_MODE);
   assign wr_filt = WR_IN && (ADDR_IN == sfct_pkg::ADDR_FILT);
   assign nxt_mode = wr_mode ? WDATA_IN : mode_ff;
   assign nxt_filter_word = wr_filt ? WDATA_IN[9:0] : filter_word_ff;

   assign third_order = mode_ff[sfct_pkg::MODE_THIRD_ORDER_SELECT_BIT]; // [R10]
   assign zero_lat = mode_ff[sfct_pkg::MODE_ZERO_LAT_BIT]; // [R06]
   // Notch only shapes the response; the rate is left as is
   assign notch = mode_ff[sfct_pkg::MODE_NOTCH_BIT]
                  && (filter_word_ff == sfct_pkg::NOTCH_FW); // [R09]
   assign settle_n = settle_periods(third_order); // [R03] [R11]

   // Mode or filter write restarts filter too, as a channel change does
   assign restart = chan_edge || wr_mode || wr_filt || !en_s2_ff; // [R04] [R12]

   sfct_period_gen u_period
   (
      .clk_in(CLK_IN),
      .nrst_in(NRST_IN),
      .restart_in(restart),
      .filter_word_in(filter_word_ff),
      .tick_out(tick)
   ); // [R02]

   // Zero latency: one flagged result per settle_n periods [R07] [R15]
   assign conv_done = tick && (phase_ff == settle_n - 3'h1);
   assign step_mid = (phase_ff != 3'h0) || !tick;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      case (state_ff)
         sfct_pkg::SFCT_IDLE:
         begin
            nxt_phase = 3'h0;
            if (en_s2_ff)
            begin
               nxt_state = sfct_pkg::SFCT_SETTLE;
            end
         end
         sfct_pkg::SFCT_SETTLE:
         begin
            if (tick)
            begin
               nxt_phase = (phase_ff == settle_n - 3'h1) ? 3'h0 : phase_ff + 3'h1;
               if (conv_done && !zero_lat)
               begin
                  nxt_state = sfct_pkg::SFCT_RUN; // [R04] [R12]
               end
            end
         end
         sfct_pkg::SFCT_RUN:
         begin
            nxt_phase = 3'h0;
            if (zero_lat)
            begin
               nxt_state = sfct_pkg::SFCT_SETTLE;
            end
         end
         default:
         begin
            nxt_state = sfct_pkg::SFCT_IDLE;
            nxt_phase = 3'h0;
         end
      endcase
      if (restart)
      begin
         nxt_phase = 3'h0;
         nxt_state = en_s2_ff ? sfct_pkg::SFCT_SETTLE : sfct_pkg::SFCT_IDLE;
      end
   end

   // Flag: zero latency every settle, normal every tick once settled [R14]
   logic flag_now;
   assign flag_now = !restart && (zero_lat ? (state_ff == sfct_pkg::SFCT_SETTLE && conv_done)
                     : ((state_ff == sfct_pkg::SFCT_RUN && tick)
                        || (state_ff == sfct_pkg::SFCT_SETTLE && conv_done)));

   // Step latency: settle_n results, plus one if it lands mid-conversion [R05] [R13]
   // In zero latency only one result is spoiled, and none if synchronous [R08]
   always_comb
   begin
      nxt_step_left = step_left_ff;
      if (step_edge)
      begin
         if (zero_lat)
         begin
            nxt_step_left = step_mid ? 3'h1 : 3'h0;
         end
         else
         begin
            nxt_step_left = settle_n + (step_mid ? sfct_pkg::STEP_EXTRA : 3'h0);
         end
      end
      else if (flag_now && step_left_ff != 3'h0)
      begin
         nxt_step_left = step_left_ff - 3'h1;
      end
      if (restart)
      begin
         nxt_step_left = 3'h0;
      end
   end

   assign nxt_rdata = (ADDR_IN == sfct_pkg::ADDR_MODE) ? mode_ff :
                      (ADDR_IN == sfct_pkg::ADDR_FILT) ? {22'h000000, filter_word_ff} :
                      (ADDR_IN == sfct_pkg::ADDR_STAT) ?
                         {24'h000000, step_left_ff, phase_ff, state_ff} :
                      conv_cnt_ff;

   always_ff @(posedge CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         mode_ff <= sfct_pkg::MODE_RST; // [R01]
         filter_word_ff <= sfct_pkg::FW_RST;
         state_ff <= sfct_pkg::SFCT_IDLE;
         phase_ff <= 3'h0;
         step_left_ff <= 3'h0;
         ready_ff <= 1'b0;
         freset_ff <= 1'b0;
         conv_cnt_ff <= 32'h0000_0000;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         mode_ff <= nxt_mode;
         filter_word_ff <= nxt_filter_word;
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         step_left_ff <= nxt_step_left;
         ready_ff <= flag_now; // [R14]
         freset_ff <= restart;
         conv_cnt_ff <= flag_now ? conv_cnt_ff + 32'h0000_0001 : conv_cnt_ff;
         rdata_ff <= RD_IN ? nxt_rdata : 32'h0000_0000;
      end
   end

   assign RDATA_OUT = rdata_ff;
   assign DATA_READY_OUT = ready_ff;
   assign FILTER_RESET_OUT = freset_ff;
   assign SETTLED_OUT = (step_left_ff == 3'h0) && (state_ff != sfct_pkg::SFCT_IDLE);
   assign THIRD_ORDER_OUT = third_order;
   assign ZERO_LATENCY_OUT = zero_lat;
   assign NOTCH_ACTIVE_OUT = notch;
endmodule // sfct_top

// >>> test/sfct_top_monitor.sv
module sfct_chk
(
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic [1:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic CHAN_CHANGE_IN,
   input wire logic ENABLE_IN,
   input wire logic DATA_READY_OUT,
   input wire logic SETTLED_OUT,
   input wire logic THIRD_ORDER_OUT,
   input wire logic ZERO_LATENCY_OUT,
   input wire logic NOTCH_ACTIVE_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] fw_ff;
   logic [31:0] gap_ff;
   logic run_ff;
   logic chan_ff;
   wire mode_wr = WR_IN && ADDR_IN == sfct_pkg::ADDR_MODE;
   wire filt_wr = WR_IN && ADDR_IN == sfct_pkg::ADDR_FILT;
   wire restart = mode_wr || filt_wr || !ENABLE_IN || (CHAN_CHANGE_IN && !chan_ff);
   // Word 0 runs as 1
   wire [31:0] per = {12'h0, (fw_ff == 10'h0) ? 10'h1 : fw_ff, 10'h0};
   wire [31:0] settle = per * (THIRD_ORDER_OUT ? 32'h3 : 32'h4);
   always_ff @(posedge CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         fw_ff <= sfct_pkg::FW_RST;
         gap_ff <= 32'h0;
         run_ff <= 1'b0;
         chan_ff <= 1'b0;
      end
      else
      begin
         chan_ff <= CHAN_CHANGE_IN;
         fw_ff <= filt_wr ? WDATA_IN[9:0] : fw_ff;
         gap_ff <= (restart || DATA_READY_OUT) ? 32'h0 : gap_ff + 32'h1;
         run_ff <= restart ? 1'b0 : (DATA_READY_OUT || run_ff);
      end
   end
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!NRST_IN);
   AST_RST_DEF: assert property ($rose(NRST_IN) |-> !THIRD_ORDER_OUT && !DATA_READY_OUT)
      else $error("reset state");
   AST_ORDER_HOLD: assert property (!$past(mode_wr) |-> $stable(THIRD_ORDER_OUT))
      else $error("order changed alone");
   AST_THIRD_ORDER_SELECT_BIT: assert property (mode_wr |=> THIRD_ORDER_OUT == $past(WDATA_IN[15]))
      else $error("order bit");
   AST_ZL_BIT: assert property (mode_wr |=> ZERO_LATENCY_OUT == $past(WDATA_IN[11]))
      else $error("zero latency bit");
   AST_NOTCH: assert property (mode_wr && fw_ff == sfct_pkg::NOTCH_FW |=>
      NOTCH_ACTIVE_OUT == $past(WDATA_IN[13]))
      else $error("notch flag");
   AST_DR_PULSE: assert property (DATA_READY_OUT |=> !DATA_READY_OUT)
      else $error("ready too long");
   AST_IDLE_QUIET: assert property ((!ENABLE_IN)[*6] |-> !DATA_READY_OUT)
      else $error("ready while idle");
   AST_NORM_GAP: assert property (DATA_READY_OUT && run_ff && !ZERO_LATENCY_OUT |-> gap_ff == per - 32'h1)
      else $error("normal period");
   AST_ZL_GAP: assert property (DATA_READY_OUT && run_ff && ZERO_LATENCY_OUT |-> gap_ff == settle - 32'h1)
      else $error("zero latency period");
   AST_FIRST: assert property (DATA_READY_OUT && !run_ff |-> gap_ff + 32'h1 >= settle && gap_ff <= settle + 32'h8)
      else $error("first result time");
   cover property (DATA_READY_OUT && run_ff && ZERO_LATENCY_OUT);
   cover property (DATA_READY_OUT && run_ff && THIRD_ORDER_OUT);
   cover property ($rose(SETTLED_OUT));
endmodule // sfct_chk

bind sfct_top sfct_chk u_chk
(
   .CLK_IN, .NRST_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .CHAN_CHANGE_IN, .ENABLE_IN,
   .DATA_READY_OUT, .SETTLED_OUT, .THIRD_ORDER_OUT, .ZERO_LATENCY_OUT, .NOTCH_ACTIVE_OUT
);

// >>> test/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk;
   logic nrst = 1'b0, wr = 1'b0, rd = 1'b0, chan = 1'b0, step = 1'b0, enable = 1'b0;
   logic rd_late = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, mode;
   logic dr, settled, third, zl, notch;
   logic [31:0] exp_q[$];
   int n_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int fw, s, p, n, k;
   sfct_top dut
   (
      .CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
      .RD_IN(rd), .CHAN_CHANGE_IN(chan), .STEP_IN(step), .ENABLE_IN(enable),
      .RDATA_OUT(rdata), .DATA_READY_OUT(dr), .FILTER_RESET_OUT(), .SETTLED_OUT(settled),
      .THIRD_ORDER_OUT(third), .ZERO_LATENCY_OUT(zl), .NOTCH_ACTIVE_OUT(notch)
   );
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic complete_run();
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Requests launch after an edge and are taken at the next one
   task automatic wreg(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= 1'b0;
      wr <= 1'b1;
   endtask
   task automatic rreg(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk);
      exp_q.push_back(d);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
   endtask
   task automatic idle(input int c);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (c) @(posedge clk);
   endtask
   task automatic wait_dr(output int c);
      c = 0;
      do
      begin
         @(negedge clk);
         c++;
      end
      while (dr !== 1'b1 && c < 20000);
   endtask
   // Counts results until the step has worked through the filter
   task automatic cnt_unsettled(output int c);
      c = 0;
      for (int i = 0; i < 40000 && settled !== 1'b1; i++)
      begin
         @(negedge clk);
         c += (dr === 1'b1);
      end
   endtask
   always @(posedge clk)
   begin
      rd_late <= rd;
      cycles++;
      if (cycles == 100000)
      begin
         n_errors++;
         complete_run();
      end
   end
   always @(negedge clk)
      if (rd_late === 1'b1 && exp_q.size() > 0)
         check(rdata, exp_q.pop_front());
   initial
   begin
      void'($urandom(32'h6FDCE0E5));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rreg(sfct_pkg::ADDR_MODE, sfct_pkg::MODE_RST);
      rreg(sfct_pkg::ADDR_FILT, {22'h0, sfct_pkg::FW_RST});
      wreg(sfct_pkg::ADDR_STAT, 32'hFFFF_FFFF);
      rreg(sfct_pkg::ADDR_MODE, sfct_pkg::MODE_RST);
      idle(1);
      @(negedge clk);
      check({29'h0, third, zl, notch}, 32'h0);
      wreg(sfct_pkg::ADDR_MODE, 32'h1 << sfct_pkg::MODE_NOTCH_BIT);
      idle(1);
      @(negedge clk);
      check({31'h0, notch}, 32'h1);
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk);
         enable <= 1'b1;
         fw = (m < 2) ? int'($urandom_range(2, 1)) : 1;
         s = (m % 2 == 1) ? 3 : 4;
         p = 1024 * fw;
         mode = 32'((m % 2) << sfct_pkg::MODE_THIRD_ORDER_SELECT_BIT) | 32'((m / 2) << 11);
         wreg(sfct_pkg::ADDR_FILT, 32'(fw));
         wreg(sfct_pkg::ADDR_MODE, mode);
         idle(0);
         wait_dr(n);
         check(32'(n + 1 >= s * p && n <= s * p + 8), 32'h1);
         wait_dr(n);
         check(32'(n), (m < 2) ? 32'(p) : 32'(s * p));
         rreg(sfct_pkg::ADDR_MODE, mode);
         rreg(sfct_pkg::ADDR_FILT, 32'(fw));
         idle(300);
         chan <= 1'b1;
         wait_dr(n);
         check(32'(n + 1 >= s * p && n <= s * p + 8), 32'h1);
         // Step lands mid-conversion, so the longer count applies
         idle(300);
         step <= 1'b1;
         idle(4);
         cnt_unsettled(k);
         check(32'(k), (m < 2) ? 32'(s + 1) : 32'h1);
         @(posedge clk);
         chan <= 1'b0;
         step <= 1'b0;
      end
      @(posedge clk);
      enable <= 1'b0;
      idle(10);
      complete_run();
   end
endmodule // tb
